// File: src/imsp_core.sv
`include "imsp_regs.svh"
module imsp_core
    import imsp_pkg::*;
#(
    parameter int AW = 13,
    parameter int IW = 16,
    parameter int WW = 2
) (
    input  wire logic          mclk,
    input  wire logic          reset,
    input  wire logic          sys_reset_n,
    input  wire logic          cfg_load,
    input  wire logic          cpu_clock_select,
    input  wire logic [WW-1:0] instr_wait_states,
    input  wire logic [WW-1:0] data_wait_states,
    input  wire logic          wait_in,
    input  wire logic          cpu_stopped,
    input  wire logic          fetch_req,
    input  wire logic [AW-1:0] fetch_addr,
    output logic               fetch_done,
    output logic [IW-1:0]      fetch_data,
    input  wire logic          data_req,
    input  wire logic          host_bus_grant,
    output logic               data_done,
    output logic               dmem_access_n,
    output logic [AW-1:0]      imem_addr,
    output logic [IW-1:0]      imem_wdata,
    output logic               imem_wdata_oe,
    input  wire logic [IW-1:0] imem_rdata,
    output logic               imem_read_n,
    output logic               instr_write_strobe_n,
    input  wire logic          host_pc_load,
    input  wire logic [AW-1:0] host_pc_value,
    input  wire logic          host_req,
    input  wire logic          host_we,
    input  wire logic [7:0]    host_wdata,
    output logic [7:0]         host_rdata,
    output logic               host_done,
    output logic               host_refused,
    output logic [AW-1:0]      host_pc
);
    logic            rst_s1_r;
    logic            rst_s2_r;
    logic            rst_int;
    logic            div_r;
    logic            t_tick;
    logic            clk_sel_r;
    logic [WW-1:0]   iws_r;
    logic [WW-1:0]   dws_r;
    imsp_ist_t       ist_r;
    imsp_dst_t       dst_r;
    logic            hi_phase_r;
    logic [7:0]      lo_byte_r;
    logic [7:0]      hi_byte_r;
    logic [AW-1:0]   pc_r;
    logic            i_start;
    logic            i_done;
    logic            d_start;
    logic            d_done;
    logic            fetch_done_r;
    logic [IW-1:0]   fetch_data_r;
    logic            data_done_r;
    logic            dmem_access_n_r;
    logic [AW-1:0]   imem_addr_r;
    logic [IW-1:0]   imem_wdata_r;
    logic            imem_wdata_oe_r;
    logic            imem_read_n_r;
    logic            iwr_n_r;
    logic [7:0]      host_rdata_r;
    logic            host_done_r;
    logic            host_refused_r;

    // First stage feeds only the second, so metastability never reaches logic
    always_ff @(posedge mclk) begin
        if (reset) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= sys_reset_n;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_int = reset || !rst_s2_r;

    // Wait states and clock rate hold their slow defaults until software loads them
    always_ff @(posedge mclk) begin
        if (rst_int) begin
            clk_sel_r <= `IMSP_RST_CLK_SEL;
            iws_r     <= `IMSP_RST_IWS;
            dws_r     <= `IMSP_RST_DWS;
        end else if (cfg_load) begin
            clk_sel_r <= cpu_clock_select;
            iws_r     <= instr_wait_states;
            dws_r     <= data_wait_states;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst_int) begin
            div_r <= 1'b0;
        end else begin
            div_r <= !div_r;
        end
    end
    assign t_tick = clk_sel_r ? div_r : 1'b1;

    // Instruction bus: CPU fetch when running, host access only when stopped
    assign i_start = (ist_r == IS_IDLE) && !i_done &&
                     ((fetch_req && !cpu_stopped) || (host_req && cpu_stopped && (!hi_phase_r || host_we) &&
                      !(hi_phase_r == 1'b0 && host_we)));

    imsp_wait_ctr #(.WW(WW)) u_ictr (
        .mclk    (mclk),
        .reset   (rst_int),
        .start   (i_start),
        .tick    (t_tick),
        .states  (iws_r),
        .wait_in (wait_in),
        .busy    (),
        .done    (i_done)
    );

    imsp_wait_ctr #(.WW(WW)) u_dctr (
        .mclk    (mclk),
        .reset   (rst_int),
        .start   (d_start),
        .tick    (t_tick),
        .states  (dws_r),
        .wait_in (wait_in),
        .busy    (),
        .done    (d_done)
    );

    always_ff @(posedge mclk) begin
        if (rst_int) begin
            ist_r           <= IS_IDLE;
            imem_addr_r     <= '0;
            imem_wdata_r    <= '0;
            imem_wdata_oe_r <= 1'b0;
            imem_read_n_r   <= 1'b1;
            iwr_n_r         <= 1'b1;
            fetch_done_r    <= 1'b0;
            fetch_data_r    <= '0;
        end else begin
            fetch_done_r <= 1'b0;
            case (ist_r)
                IS_IDLE: begin
                    imem_wdata_oe_r <= 1'b0; // Data held one clock past the strobe edge
                    if (i_start && !cpu_stopped) begin
                        ist_r         <= IS_FETCH;
                        imem_addr_r   <= fetch_addr;
                        imem_read_n_r <= 1'b0;
                    end else if (i_start && !host_we) begin
                        ist_r         <= IS_HRD;
                        imem_addr_r   <= pc_r;
                        imem_read_n_r <= 1'b0;
                    end else if (i_start) begin
                        ist_r           <= IS_HWR;
                        imem_addr_r     <= pc_r;
                        imem_wdata_r    <= {host_wdata, lo_byte_r};
                        imem_wdata_oe_r <= 1'b1;
                        iwr_n_r         <= 1'b0;
                    end
                end
                IS_FETCH: begin
                    if (i_done) begin
                        ist_r         <= IS_IDLE;
                        imem_read_n_r <= 1'b1;
                        fetch_data_r  <= imem_rdata;
                        fetch_done_r  <= 1'b1;
                    end
                end
                IS_HRD: begin
                    if (i_done) begin
                        ist_r         <= IS_IDLE;
                        imem_read_n_r <= 1'b1;
                    end
                end
                IS_HWR: begin
                    if (i_done) begin
                        ist_r   <= IS_IDLE;
                        iwr_n_r <= 1'b1;
                    end
                end
                default: ist_r <= IS_IDLE;
            endcase
        end
    end

    // Host byte path: low byte first, counter steps after the high byte
    always_ff @(posedge mclk) begin
        if (rst_int) begin
            hi_phase_r     <= 1'b0;
            lo_byte_r      <= '0;
            hi_byte_r      <= '0;
            pc_r           <= '0;
            host_rdata_r   <= '0;
            host_done_r    <= 1'b0;
            host_refused_r <= 1'b0;
        end else begin
            host_done_r    <= 1'b0;
            host_refused_r <= 1'b0;
            if (host_pc_load) begin
                pc_r       <= host_pc_value;
                hi_phase_r <= 1'b0;
            end else if (host_req && !cpu_stopped) begin
                host_refused_r <= 1'b1;
            end else if (ist_r == IS_HRD && i_done) begin
                lo_byte_r    <= imem_rdata[7:0];
                hi_byte_r    <= imem_rdata[IW-1:8];
                host_rdata_r <= imem_rdata[7:0];
                hi_phase_r   <= 1'b1;
                host_done_r  <= 1'b1;
            end else if (ist_r == IS_HWR && i_done) begin
                pc_r        <= pc_r + AW'(`IMSP_PC_STEP);
                hi_phase_r  <= 1'b0;
                host_done_r <= 1'b1;
            end else if (host_req && ist_r == IS_IDLE && !hi_phase_r && host_we) begin
                lo_byte_r   <= host_wdata;
                hi_phase_r  <= 1'b1;
                host_done_r <= 1'b1;
            end else if (host_req && ist_r == IS_IDLE && hi_phase_r && !host_we) begin
                host_rdata_r <= hi_byte_r;
                pc_r         <= pc_r + AW'(`IMSP_PC_STEP);
                hi_phase_r   <= 1'b0;
                host_done_r  <= 1'b1;
            end
        end
    end

    // Data bus runs beside the instruction bus; it waits while the host holds it
    assign d_start = (dst_r != DS_ACC) && data_req && !host_bus_grant && !data_done_r;

    always_ff @(posedge mclk) begin
        if (rst_int) begin
            dst_r           <= DS_IDLE;
            dmem_access_n_r <= 1'b1;
            data_done_r     <= 1'b0;
        end else begin
            data_done_r <= 1'b0;
            case (dst_r)
                DS_IDLE, DS_STALL: begin
                    if (d_start) begin
                        dst_r           <= DS_ACC;
                        dmem_access_n_r <= 1'b0;
                    end else if (data_req && host_bus_grant) begin
                        dst_r <= DS_STALL;
                    end else begin
                        dst_r <= DS_IDLE;
                    end
                end
                DS_ACC: begin
                    if (d_done) begin
                        dst_r           <= DS_IDLE;
                        dmem_access_n_r <= 1'b1;
                        data_done_r     <= 1'b1;
                    end
                end
                default: dst_r <= DS_IDLE;
            endcase
        end
    end

    assign fetch_done           = fetch_done_r;
    assign fetch_data           = fetch_data_r;
    assign data_done            = data_done_r;
    assign dmem_access_n        = dmem_access_n_r;
    assign imem_addr            = imem_addr_r;
    assign imem_wdata           = imem_wdata_r;
    assign imem_wdata_oe        = imem_wdata_oe_r;
    assign imem_read_n          = imem_read_n_r;
    assign instr_write_strobe_n = iwr_n_r;
    assign host_rdata           = host_rdata_r;
    assign host_done            = host_done_r;
    assign host_refused         = host_refused_r;
    assign host_pc              = pc_r;
endmodule // imsp_core

// File: shared/imsp_regs.svh
`ifndef IMSP_REGS_SVH
`define IMSP_REGS_SVH
// Configuration after reset: half speed and the most wait states
`define IMSP_RST_CLK_SEL    1'b1
`define IMSP_RST_IWS        2'h3
`define IMSP_RST_DWS        2'h3
`define IMSP_WS_ZERO        2'h0
`define IMSP_PC_STEP        1
`endif

// File: shared/imsp_pkg.sv
package imsp_pkg;
    typedef enum logic [1:0] {IS_IDLE, IS_FETCH, IS_HRD, IS_HWR} imsp_ist_t;
    typedef enum logic [1:0] {DS_IDLE, DS_STALL, DS_ACC} imsp_dst_t;
endpackage

// File: src/imsp_wait_ctr.sv
`include "imsp_regs.svh"
module imsp_wait_ctr #(
    parameter int WW = 2
) (
    input  wire logic          mclk,
    input  wire logic          reset,
    input  wire logic          start,
    input  wire logic          tick,
    input  wire logic [WW-1:0] states,
    input  wire logic          wait_in,
    output logic               busy,
    output logic               done
);
    logic [WW-1:0] cnt_r;
    logic          busy_r;

    // Access spans states+1 T-states, then extra T-states while wait_in holds
    assign done = busy_r && tick && (cnt_r == `IMSP_WS_ZERO) && !wait_in;
    assign busy = busy_r;

    always_ff @(posedge mclk) begin
        if (reset) begin
            busy_r <= 1'b0;
            cnt_r  <= '0;
        end else if (start) begin
            busy_r <= 1'b1;
            cnt_r  <= states;
        end else if (done) begin
            busy_r <= 1'b0;
        end else if (busy_r && tick && cnt_r != `IMSP_WS_ZERO) begin
            cnt_r  <= cnt_r - WW'(`IMSP_PC_STEP);
        end
    end
endmodule // imsp_wait_ctr

// File: test/imsp_imem_model.sv
module imsp_imem_model #(
    parameter int AW = 13,
    parameter int IW = 16
) (
    input  wire logic          mclk,
    input  wire logic [AW-1:0] imem_addr,
    input  wire logic [IW-1:0] imem_wdata,
    input  wire logic          imem_wdata_oe,
    input  wire logic          imem_read_n,
    input  wire logic          instr_write_strobe_n,
    output logic [IW-1:0]      imem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [IW-1:0] mem [0:(1<<AW)-1];
    logic [IW-1:0] last_r;
    initial begin
        for (int i = 0; i < (1 << AW); i++) begin
            mem[i] = IW'(i) ^ 16'h5a00;
        end
        last_r = 16'h0000;
    end
    // Latch on the strobe's rising edge, when the word must already be settled
    always @(posedge instr_write_strobe_n) begin
        if (imem_wdata_oe === 1'b1) begin
            mem[imem_addr] <= imem_wdata;
        end
    end
    always @(posedge mclk) begin
        if (!imem_read_n) begin
            last_r <= mem[imem_addr];
        end
    end
    // Deselected: show the inverse so a late sample cannot pass by luck
    assign imem_rdata = imem_read_n ? ~last_r : mem[imem_addr];
endmodule // imsp_imem_model

// File: test/imsp_core_monitor.sv
module imsp_core_monitor #(
    parameter int AW = 13,
    parameter int IW = 16
) (
    input wire logic          mclk,
    input wire logic          reset,
    input wire logic          sys_reset_n,
    input wire logic          cpu_stopped,
    input wire logic          host_req,
    input wire logic          host_refused,
    input wire logic          host_done,
    input wire logic          host_bus_grant,
    input wire logic          dmem_access_n,
    input wire logic          data_done,
    input wire logic          fetch_done,
    input wire logic          imem_read_n,
    input wire logic          instr_write_strobe_n,
    input wire logic          imem_wdata_oe,
    input wire logic [IW-1:0] imem_wdata,
    input wire logic [AW-1:0] imem_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset || !sys_reset_n);
    a_refuse_running: assert property (host_req && !cpu_stopped |=> host_refused && !host_done)
        else $error("host request while running not refused");
    a_accept_stopped: assert property (host_req && cpu_stopped |=> !host_refused)
        else $error("host request while stopped was refused");
    a_write_stopped: assert property (!instr_write_strobe_n |-> cpu_stopped && imem_wdata_oe)
        else $error("instruction write without stopped cpu or driven bus");
    a_write_word_held: assert property (!instr_write_strobe_n && !$past(instr_write_strobe_n)
        |-> $stable(imem_wdata) && $stable(imem_addr))
        else $error("word or address moved during write strobe");
    a_write_then_done: assert property ($rose(instr_write_strobe_n) |-> ##[0:2] host_done)
        else $error("no host completion after write strobe");
    a_grant_stalls: assert property (host_bus_grant && dmem_access_n |=> dmem_access_n)
        else $error("data access started while host owns bus");
    a_data_bounded: assert property ($fell(dmem_access_n) |-> ##[1:60] data_done)
        else $error("data access did not complete");
    a_fetch_bounded: assert property ($fell(imem_read_n) && !cpu_stopped |-> ##[1:60] fetch_done)
        else $error("fetch did not complete");
    a_read_addr_held: assert property (!imem_read_n && !$past(imem_read_n) |-> $stable(imem_addr))
        else $error("address moved during read");
    a_read_write_excl: assert property (!imem_read_n |-> instr_write_strobe_n)
        else $error("read and write strobes together");
    c_fetch_with_data: cover property (!imem_read_n && !dmem_access_n);
    c_softload_write: cover property ($rose(instr_write_strobe_n));
    c_host_refused: cover property (host_refused);
endmodule // imsp_core_monitor

bind imsp_core imsp_core_monitor #(.AW(AW), .IW(IW)) mon_u (.mclk(mclk), .reset(reset), .sys_reset_n(sys_reset_n),
    .cpu_stopped(cpu_stopped), .host_req(host_req), .host_refused(host_refused), .host_done(host_done),
    .host_bus_grant(host_bus_grant), .dmem_access_n(dmem_access_n), .data_done(data_done),
    .fetch_done(fetch_done), .imem_read_n(imem_read_n), .instr_write_strobe_n(instr_write_strobe_n),
    .imem_wdata_oe(imem_wdata_oe), .imem_wdata(imem_wdata), .imem_addr(imem_addr));

// File: test/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, reset = 1, sys_reset_n = 1, cfg_load = 0, cpu_clock_select = 1, wait_in = 0, cpu_stopped = 0;
    logic [1:0] instr_wait_states = 2'h3, data_wait_states = 2'h3;
    logic fetch_req = 0, data_req = 0, host_bus_grant = 0, host_pc_load = 0, host_req = 0, host_we = 0;
    logic [12:0] fetch_addr = 13'h0000, host_pc_value = 13'h0000, imem_addr, host_pc;
    logic [15:0] fetch_data, imem_wdata, imem_rdata;
    logic [7:0] host_wdata = 8'h00, host_rdata;
    logic fetch_done, data_done, dmem_access_n, imem_wdata_oe, imem_read_n, instr_write_strobe_n;
    logic host_done, host_refused;
    int num_errors = 0, n_compared = 0, cnt;
    always #25 mclk = ~mclk;
    imsp_core dut_u (.mclk(mclk), .reset(reset), .sys_reset_n(sys_reset_n), .cfg_load(cfg_load),
        .cpu_clock_select(cpu_clock_select), .instr_wait_states(instr_wait_states),
        .data_wait_states(data_wait_states), .wait_in(wait_in), .cpu_stopped(cpu_stopped),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_done(fetch_done), .fetch_data(fetch_data),
        .data_req(data_req), .host_bus_grant(host_bus_grant), .data_done(data_done),
        .dmem_access_n(dmem_access_n), .imem_addr(imem_addr), .imem_wdata(imem_wdata),
        .imem_wdata_oe(imem_wdata_oe), .imem_rdata(imem_rdata), .imem_read_n(imem_read_n),
        .instr_write_strobe_n(instr_write_strobe_n), .host_pc_load(host_pc_load),
        .host_pc_value(host_pc_value), .host_req(host_req), .host_we(host_we), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .host_done(host_done), .host_refused(host_refused), .host_pc(host_pc));
    imsp_imem_model mem_u (.mclk(mclk), .imem_addr(imem_addr), .imem_wdata(imem_wdata),
        .imem_wdata_oe(imem_wdata_oe), .imem_read_n(imem_read_n),
        .instr_write_strobe_n(instr_write_strobe_n), .imem_rdata(imem_rdata));
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Samples at this and later falling edges, so one-cycle pulses are never missed
    task automatic wait_done(ref logic done, ref logic strobe_n);
        cnt = 0;
        for (int i = 0; i < 100; i++) begin
            if (strobe_n === 1'b0) cnt++;
            if (done === 1'b1) break;
            @(negedge mclk);
        end
    endtask
    // Stretch holds wait_in high for that many extra cycles; early samples are added back
    task automatic fetch(logic [12:0] a, int lo, int hi, int stretch);
        @(negedge mclk);
        fetch_req = 1;
        fetch_addr = a;
        wait_in = (stretch > 0);
        repeat (stretch + 1) @(negedge mclk);
        wait_in = 0;
        wait_done(fetch_done, imem_read_n);
        check("fetch_done", fetch_done, 1'b1);
        check("fetch_data", fetch_data, {3'h0, a} ^ 16'h5a00);
        check("read_width_ok", 16'(cnt + stretch >= lo && cnt + stretch <= hi), 16'h0001);
        fetch_req = 0;
    endtask
    task automatic host_op(logic we, logic [7:0] d, int lo, int hi);
        @(negedge mclk);
        host_req = 1;
        host_we = we;
        host_wdata = d;
        @(negedge mclk);
        host_req = 0;
        wait_done(host_done, instr_write_strobe_n);
        check("host_done", host_done, 1'b1);
        check("strobe_width_ok", 16'(cnt >= lo && cnt <= hi), 16'h0001);
    endtask
    task automatic set_pc(logic [12:0] v);
        @(negedge mclk);
        host_pc_load = 1;
        host_pc_value = v;
        @(negedge mclk);
        host_pc_load = 0;
    endtask
    // Write one word, read it back; only the high-byte write strobe width is checked, (ws+1) T-states of t mclk
    task automatic softload(logic [12:0] a, logic [15:0] w, int t, int ws);
        cpu_stopped = 1;
        set_pc(a);
        host_op(1, w[7:0], 0, 0);
        host_op(1, w[15:8], (ws + 1) * t - t + 1, (ws + 1) * t);
        check("pc_after_write", host_pc, 13'(a + 13'h0001));
        check("word_stored", mem_u.mem[a], w);
        set_pc(a);
        host_op(0, 8'h00, 0, 0);
        check("read_low", host_rdata, w[7:0]);
        host_op(0, 8'h00, 0, 0);
        check("read_high", host_rdata, w[15:8]);
        check("pc_after_read", host_pc, 13'(a + 13'h0001));
        host_op(1, 8'h00, 0, 0);
        cpu_stopped = 0;
    endtask
    task automatic refuse_and_reset();
        set_pc(13'h0009);
        @(negedge mclk);
        host_req = 1;
        host_we = 1;
        @(negedge mclk);
        host_req = 0;
        check("refused", host_refused, 1'b1);
        sys_reset_n = 0;
        repeat (20) @(negedge mclk);
        sys_reset_n = 1;
        repeat (4) @(negedge mclk);
        check("pc_cleared", host_pc, 13'h0000);
    endtask
    task automatic fetch_with_data();
        @(negedge mclk);
        data_req = 1;
        host_bus_grant = 1;
        fetch(13'h0042, 1, 1, 0);
        check("data_stalled", dmem_access_n, 1'b1);
        host_bus_grant = 0;
        wait_done(data_done, dmem_access_n);
        check("data_done", data_done, 1'b1);
        check("data_width", 16'(cnt), 16'h0001);
        fetch(13'h0043, 1, 1, 0);
        check("data_beside_fetch", data_done, 1'b1);
        data_req = 0;
    endtask
    initial begin
        #(20000 * 50);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(negedge mclk);
        reset = 0;
        @(negedge mclk);
        check("strobes_idle", {instr_write_strobe_n, imem_read_n, dmem_access_n, imem_wdata_oe}, 4'he);
        fetch(13'h0010, 7, 8, 0);
        softload(13'h0100, 16'h1234, 2, 3);
        refuse_and_reset();
        @(negedge mclk);
        cfg_load = 1;
        cpu_clock_select = 0;
        instr_wait_states = 2'h0;
        data_wait_states = 2'h0;
        @(negedge mclk);
        cfg_load = 0;
        fetch(13'h0011, 1, 1, 0);
        fetch_with_data();
        softload(13'h1fff, 16'hbeef, 1, 0);
        fetch(13'h0012, 3, 3, 2);
        tally_and_finish();
    end
endmodule // tb_top
